// ==== rtl/lmt_device.sv ====
// Purpose: Device end of the LPC memory target with hardware write protect
// Assumes: Host end keeps its own framing; flash core answers reads within 3 clocks
// Notes:   Program/erase engine lives outside; this end only issues or refuses writes
// Summary of operation
// - Last clock with frame low and 0000 starts
// - Cycle type 010x read, 011x write
// - Eight address nibbles, most significant first
// - Host drives 1111 then floats LAD
// - Device takes bus on the following clock, driving sync at once
// - Read waits with two wait-sync clocks
// - One ready-sync clock, then data follows
// - Read data low nibble, then high nibble
// - Device drives 1111, then floats LAD
// - Write data low nibble, then high nibble
// - Write acknowledged by one ready clock
// - Fields valid and sampled on rising edge
// - Unselected device keeps LAD released
// - Frame low mid-cycle releases LAD, resets machine
// - Abort never stops a started flash operation
// - No flash operation before final data nibble
// - Top-lock pin low blocks top sector writes
// - Write-protect pin blocks all other sectors
// - Protect pins followed while flash is idle, held while busy
// - Pins override register lock; read lock works
// - Bit 23 selects array, bits 22:19 ID
// - Seeing frame low stops driving next clock
// - Reset restores array read and write locks
`timescale 1ns/10ps
module lmt_device
  import lmt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       ce_i,
  // Bus
  lmt_lpc_if.device       bus,
  // Pins
  input  wire logic [3:0] id_strap_i,
  input  wire logic       top_sector_lock_n_i,
  input  wire logic       write_protect_n_i,
  // Flash core
  input  wire logic       busy_i,
  input  wire logic [7:0] mem_rd_data_i,
  output logic            mem_rd_o,
  output logic [18:0]     mem_addr_o,
  output logic            prog_o,
  output logic [7:0]      prog_data_o,
  output logic            wr_blocked_o
);

  typedef struct packed {
    lmt_dev_state_t   st;
    logic [3:0]       cnt;
    logic             wr;
    logic [31:0]      addr;
    logic [7:0]       data;
    logic [3:0]       lad;
    logic             lad_oe;
    logic             mem_rd;
    logic             prog;
    logic             blocked;
    logic             tbl_hold;
    logic             wp_hold;
    logic [10:0][2:0] lock;
  } lmt_dev_regs_t;

  localparam lmt_dev_regs_t DEV_RST = '{st: D_IDLE, cnt: 4'h0, wr: 1'b0, addr: 32'h0, data: 8'h0,
    lad: LMT_TAR_CODE, lad_oe: 1'b0, mem_rd: 1'b0, prog: 1'b0, blocked: 1'b0, tbl_hold: 1'b1,
    wp_hold: 1'b1, lock: LMT_LOCK_RESET};

  lmt_dev_regs_t r;
  lmt_dev_regs_t next_r;
  logic [5:0]    pins_s;
  logic [3:0]    id_s;
  logic          tbl_s;
  logic          wp_s;

  // Straps and protect pins are asynchronous to the bus clock
  lmt_sync2 #(.W(6)) u_pins (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .d_i       ({id_strap_i, top_sector_lock_n_i, write_protect_n_i}),
    .q_o       (pins_s)
  );

  assign id_s  = pins_s[5:2];
  assign tbl_s = pins_s[1];
  assign wp_s  = pins_s[0];

  always_comb begin
    logic [31:0] full_addr;
    logic [3:0]  sec;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic [3:0]  drv;
    logic        is_reg;
    logic        hw_block;
    full_addr = {r.addr[27:0], bus.lad};
    sec       = lmt_sector(r.addr[18:0]);
    wbyte     = {bus.lad, r.data[3:0]};
    drv       = LMT_TAR_CODE;
    rbyte     = LMT_BLANK_DATA;
    is_reg    = (r.addr[18:0] == (LMT_SEC_BASE[sec] | LMT_LOCK_REG_OFS));
    hw_block  = (sec == LMT_TOP_SECTOR) ? !r.tbl_hold : !r.wp_hold;
    if (r.addr[LMT_SEL_BIT]) begin
      rbyte = r.lock[sec][LMT_RLOCK_BIT] ? LMT_BLANK_DATA : mem_rd_data_i;
    end else begin
      rbyte = is_reg ? {5'h00, r.lock[sec]} : LMT_BLANK_DATA;
    end

    next_r         = r;
    next_r.mem_rd  = 1'b0;
    next_r.prog    = 1'b0;
    next_r.blocked = 1'b0;
    // Pins only follow while no operation runs
    if (!busy_i) begin
      next_r.tbl_hold = tbl_s;
      next_r.wp_hold  = wp_s;
    end

    if (!bus.lframe_n) begin
      next_r.lad_oe = 1'b0;
      next_r.lad    = LMT_TAR_CODE;
      next_r.cnt    = 4'h0;
      next_r.st     = (bus.lad == LMT_START_CODE) ? D_START : D_IDLE;
    end else begin
      case (r.st)
        D_IDLE: begin
          next_r.lad_oe = 1'b0;
        end
        D_START: begin
          if (bus.lad[3:2] == LMT_MEM_TYPE) begin
            next_r.wr  = bus.lad[LMT_DIR_BIT];
            next_r.st  = D_ADDR;
            next_r.cnt = 4'h0;
          end else begin
            next_r.st = D_IGNORE;
          end
        end
        D_ADDR: begin
          next_r.addr = full_addr;
          next_r.cnt  = r.cnt + 4'h1;
          if (r.cnt == LMT_ADDR_LAST) begin
            next_r.cnt = 4'h0;
            if (full_addr[LMT_ID_MSB:LMT_ID_LSB] != id_s) begin
              next_r.st = D_IGNORE;
            end else if (r.wr) begin
              next_r.st = D_WDATA;
            end else begin
              next_r.st     = D_TAR;
              next_r.mem_rd = full_addr[LMT_SEL_BIT];
            end
          end
        end
        D_WDATA: begin
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == 4'h0) begin
            next_r.data[3:0] = bus.lad;
          end else begin
            next_r.data = wbyte;
            next_r.st   = D_TAR;
            next_r.cnt  = 4'h0;
            // Action only once the last nibble is in; a later abort cannot undo it
            if (r.addr[LMT_SEL_BIT]) begin
              if (hw_block || r.lock[sec][LMT_WLOCK_BIT]) begin
                next_r.blocked = 1'b1;
              end else begin
                next_r.prog = 1'b1;
              end
            end else if (is_reg && !r.lock[sec][LMT_DOWN_BIT]) begin
              next_r.lock[sec] = wbyte[2:0];
            end
          end
        end
        D_TAR: begin
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt != 4'h0) begin
            next_r.st     = D_DRIVE;
            next_r.cnt    = 4'h0;
            next_r.lad_oe = 1'b1;
            next_r.lad    = r.wr ? LMT_READY_SYNC_CODE : LMT_WAIT_SYNC_CODE;
          end
        end
        D_DRIVE: begin
          next_r.cnt = r.cnt + 4'h1;
          if (!r.wr && r.cnt == LMT_RD_LATCH) begin
            next_r.data = rbyte;
          end
          if (r.wr) begin
            drv = LMT_TAR_CODE;
          end else begin
            case (r.cnt)
              4'h0:    drv = LMT_WAIT_SYNC_CODE;
              4'h1:    drv = LMT_READY_SYNC_CODE;
              4'h2:    drv = r.data[3:0];
              4'h3:    drv = r.data[7:4];
              default: drv = LMT_TAR_CODE;
            endcase
          end
          next_r.lad = drv;
          if (r.cnt == (r.wr ? LMT_WR_LAST : LMT_RD_LAST)) begin
            next_r.lad_oe = 1'b0;
            next_r.st     = D_IDLE;
            next_r.cnt    = 4'h0;
          end
        end
        D_IGNORE: begin
          next_r.lad_oe = 1'b0;
        end
        default: begin
          next_r.st     = D_IDLE;
          next_r.lad_oe = 1'b0;
        end
      endcase
    end
  end

  // Reset brings back array reads and default write locks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= DEV_RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign bus.dev_lad    = r.lad;
  assign bus.dev_lad_oe = r.lad_oe;
  assign mem_rd_o       = r.mem_rd;
  assign mem_addr_o     = r.addr[18:0];
  assign prog_o         = r.prog;
  assign prog_data_o    = r.data;
  assign wr_blocked_o   = r.blocked;

endmodule

// ==== shared/lmt_pkg.sv ====
// Purpose: Shared constants, types and decode helpers for the LPC memory target
// Assumes: One 50 MHz clock shared by host end and device end
// Notes:   Cycle counts are in bus clocks
package lmt_pkg;

  // Field codes on the nibble bus
  localparam logic [3:0] LMT_START_CODE      = 4'h0;
  localparam logic [3:0] LMT_WAIT_SYNC_CODE  = 4'h5;
  localparam logic [3:0] LMT_READY_SYNC_CODE = 4'h0;
  localparam logic [3:0] LMT_TAR_CODE        = 4'hf;
  localparam logic [1:0] LMT_MEM_TYPE        = 2'h1;
  localparam int         LMT_DIR_BIT         = 1;

  // Address layout
  localparam int LMT_SEL_BIT = 23;
  localparam int LMT_ID_MSB  = 22;
  localparam int LMT_ID_LSB  = 19;

  // Cycle counts
  localparam logic [3:0] LMT_ADDR_LAST    = 4'h7;
  localparam logic [3:0] LMT_HOST_ADDR_END = 4'h8;
  localparam logic [3:0] LMT_RD_LATCH     = 4'h1;
  localparam logic [3:0] LMT_RD_LAST      = 4'h5;
  localparam logic [3:0] LMT_WR_LAST      = 4'h1;
  localparam logic [3:0] LMT_SYNC_TIMEOUT = 4'h8;
  localparam logic [3:0] LMT_ABORT_LAST   = 4'h3;

  // Sector layout and lock registers
  localparam int                 LMT_SECTORS      = 11;
  localparam logic [3:0]         LMT_TOP_SECTOR   = 4'ha;
  localparam logic [2:0]         LMT_LOCK_DEFAULT = 3'h1;
  localparam logic [10:0][2:0]   LMT_LOCK_RESET   = {LMT_SECTORS{LMT_LOCK_DEFAULT}};
  localparam logic [18:0]        LMT_LOCK_REG_OFS = 19'h00002;
  localparam logic [7:0]         LMT_BLANK_DATA   = 8'hff;
  localparam int                 LMT_WLOCK_BIT    = 0;
  localparam int                 LMT_DOWN_BIT     = 1;
  localparam int                 LMT_RLOCK_BIT    = 2;
  localparam logic [18:0] LMT_SEC_BASE [0:10] = '{19'h00000, 19'h10000, 19'h20000, 19'h30000,
    19'h40000, 19'h50000, 19'h60000, 19'h70000, 19'h74000, 19'h76000, 19'h78000};

  typedef enum logic [2:0] {
    D_IDLE   = 3'b000,
    D_START  = 3'b001,
    D_ADDR   = 3'b010,
    D_WDATA  = 3'b011,
    D_TAR    = 3'b100,
    D_DRIVE  = 3'b101,
    D_IGNORE = 3'b110
  } lmt_dev_state_t;

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0000,
    H_START = 4'b0001,
    H_ADDR  = 4'b0010,
    H_WDATA = 4'b0011,
    H_TAR0  = 4'b0100,
    H_TAR1  = 4'b0101,
    H_SYNC  = 4'b0110,
    H_RDATA = 4'b0111,
    H_BTAR  = 4'b1000,
    H_ABORT = 4'b1001
  } lmt_host_state_t;

  function automatic logic [3:0] lmt_sector(input logic [18:0] a);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 1; i < LMT_SECTORS; i++) begin
      if (a >= LMT_SEC_BASE[i]) begin
        s = 4'(i);
      end
    end
    return s;
  endfunction

endpackage

// ==== shared/lmt_lpc_if.sv ====
// Purpose: Nibble bus between host end and device end
// Assumes: Both ends on the same clock
// Notes:   Undriven lines read high, as with bus pull-ups
`timescale 1ns/10ps
interface lmt_lpc_if;
  logic       lframe_n;
  logic [3:0] host_lad;
  logic       host_lad_oe;
  logic [3:0] dev_lad;
  logic       dev_lad_oe;
  logic [3:0] lad;

  // Host wins a clash so an abort is always seen
  assign lad = host_lad_oe ? host_lad : (dev_lad_oe ? dev_lad : 4'hf);

  modport host (output lframe_n, output host_lad, output host_lad_oe, input lad);
  modport device (input lframe_n, input lad, output dev_lad, output dev_lad_oe);
endinterface

// ==== rtl/lmt_sync2.sv ====
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: Inputs change slowly compared to the clock
// Notes:   Only the second stage may be read
`timescale 1ns/10ps
module lmt_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         ce_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lmt_sync_regs_t;

  lmt_sync_regs_t r;
  lmt_sync_regs_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign q_o = r.s2;
endmodule

// ==== rtl/lmt_host.sv ====
// Purpose: Host end issuing single-byte memory reads and writes
// Assumes: Device end on the same clock; protect pins are set by the system
// Notes:   A missing sync for several clocks ends in an abort
`timescale 1ns/10ps
module lmt_host
  import lmt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  // Bus
  lmt_lpc_if.host          bus,
  // Command
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [31:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_wdata_i,
  input  wire logic        abort_i,
  // Answer
  output logic             cmd_ready_o,
  output logic             done_o,
  output logic             error_o,
  output logic [7:0]       rdata_o
);

  typedef struct packed {
    lmt_host_state_t st;
    logic [3:0]      cnt;
    logic            wr;
    logic [31:0]     addr;
    logic [7:0]      data;
    logic [7:0]      rdata;
    logic            lframe_n;
    logic [3:0]      lad;
    logic            lad_oe;
    logic            ready;
    logic            done;
    logic            err;
  } lmt_host_regs_t;

  localparam lmt_host_regs_t HOST_RST = '{st: H_IDLE, cnt: 4'h0, wr: 1'b0, addr: 32'h0, data: 8'h0,
    rdata: 8'h0, lframe_n: 1'b1, lad: LMT_TAR_CODE, lad_oe: 1'b0, ready: 1'b1, done: 1'b0, err: 1'b0};

  lmt_host_regs_t r;
  lmt_host_regs_t next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    case (r.st)
      H_IDLE: begin
        if (cmd_valid_i) begin
          next_r.wr       = cmd_write_i;
          next_r.addr     = cmd_addr_i;
          next_r.data     = cmd_wdata_i;
          next_r.err      = 1'b0;
          next_r.lframe_n = 1'b0;
          next_r.lad      = LMT_START_CODE;
          next_r.lad_oe   = 1'b1;
          next_r.st       = H_START;
        end
      end
      H_START: begin
        next_r.lframe_n = 1'b1;
        next_r.lad      = {LMT_MEM_TYPE, r.wr, 1'b0};
        next_r.cnt      = 4'h0;
        next_r.st       = H_ADDR;
      end
      H_ADDR: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt != LMT_HOST_ADDR_END) begin
          next_r.lad  = r.addr[31:28];
          next_r.addr = {r.addr[27:0], 4'h0};
        end else if (r.wr) begin
          next_r.lad = r.data[3:0];
          next_r.cnt = 4'h0;
          next_r.st  = H_WDATA;
        end else begin
          next_r.lad = LMT_TAR_CODE;
          next_r.st  = H_TAR0;
        end
      end
      H_WDATA: begin
        next_r.lad = r.data[7:4];
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt != 4'h0) begin
          next_r.lad = LMT_TAR_CODE;
          next_r.st  = H_TAR0;
        end
      end
      H_TAR0: begin
        next_r.lad_oe = 1'b0;
        next_r.st     = H_TAR1;
      end
      H_TAR1: begin
        next_r.cnt = 4'h0;
        next_r.st  = H_SYNC;
      end
      H_SYNC: begin
        if (bus.lad == LMT_READY_SYNC_CODE) begin
          next_r.cnt = 4'h0;
          next_r.st  = r.wr ? H_BTAR : H_RDATA;
        end else if (bus.lad == LMT_WAIT_SYNC_CODE) begin
          next_r.cnt = 4'h0;
        end else begin
          next_r.cnt = r.cnt + 4'h1;
        end
      end
      H_RDATA: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == 4'h0) begin
          next_r.rdata[3:0] = bus.lad;
        end else begin
          next_r.rdata[7:4] = bus.lad;
          next_r.cnt        = 4'h0;
          next_r.st         = H_BTAR;
        end
      end
      H_BTAR: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt != 4'h0) begin
          next_r.done = 1'b1;
          next_r.st   = H_IDLE;
        end
      end
      H_ABORT: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == LMT_ABORT_LAST) begin
          next_r.lframe_n = 1'b1;
          next_r.lad_oe   = 1'b0;
          next_r.done     = 1'b1;
          next_r.err      = 1'b1;
          next_r.st       = H_IDLE;
        end
      end
      default: begin
        next_r = HOST_RST;
      end
    endcase
    // Silent device or user request ends the cycle with frame low and 1111
    if ((abort_i && r.st != H_IDLE && r.st != H_ABORT) ||
        (r.st == H_SYNC && r.cnt == LMT_SYNC_TIMEOUT)) begin
      next_r.lframe_n = 1'b0;
      next_r.lad      = LMT_TAR_CODE;
      next_r.lad_oe   = 1'b1;
      next_r.cnt      = 4'h0;
      next_r.st       = H_ABORT;
    end
    next_r.ready = (next_r.st == H_IDLE);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= HOST_RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign bus.lframe_n    = r.lframe_n;
  assign bus.host_lad    = r.lad;
  assign bus.host_lad_oe = r.lad_oe;
  assign cmd_ready_o     = r.ready;
  assign done_o          = r.done;
  assign error_o         = r.err;
  assign rdata_o         = r.rdata;

endmodule

// ==== sim/lmt_checker.sv ====
// Purpose: Protocol checks on the nibble bus between host end and device end
// Assumes: One clock; sees the interface signals only
// Notes:   Counter restarts on every start clock, so the last start wins
`timescale 1ns/10ps
module lmt_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  // Bus
  input wire logic       lframe_n,
  input wire logic [3:0] host_lad,
  input wire logic       host_lad_oe,
  input wire logic [3:0] dev_lad,
  input wire logic       dev_lad_oe,
  input wire logic [3:0] lad
);
  logic [4:0] cnt;
  logic       dir;
  logic       typ;

  // Clock N of a cycle samples cnt as N-1
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 5'h00;
      dir <= 1'b0;
      typ <= 1'b0;
    end else begin
      typ <= !lframe_n && lad == 4'h0;
      if (!lframe_n) begin
        cnt <= (lad == 4'h0) ? 5'h01 : 5'h00;
      end else if (cnt != 5'h00 && cnt != 5'h1f) begin
        cnt <= cnt + 5'h01;
      end
      if (typ && lframe_n) begin
        dir <= lad[1];
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_frame_stops_drive: assert property (!lframe_n |=> !dev_lad_oe)
    else $error("device drives after frame low");
  a_type_after_start: assert property ((!lframe_n && lad == 4'h0) ##1 lframe_n |-> lad[3:2] == 2'b01)
    else $error("no memory type after start");
  a_host_hands_over: assert property (lframe_n && cnt == (dir ? 5'd12 : 5'd10) |->
    host_lad_oe && host_lad == 4'hf ##1 !host_lad_oe)
    else $error("host turnaround misplaced");
  a_host_float_ones: assert property ($fell(host_lad_oe) |-> $past(host_lad) == 4'hf)
    else $error("host released without ones");
  a_sync_turn: assert property ($rose(dev_lad_oe) |-> cnt == (dir ? 5'd14 : 5'd12) &&
    !$past(host_lad_oe) && dev_lad == (dir ? 4'h0 : 4'h5))
    else $error("device takes bus at wrong clock");
  a_read_waits: assert property ($rose(dev_lad_oe) && dev_lad == 4'h5 |=>
    dev_lad_oe && dev_lad == 4'h5 ##1 dev_lad_oe && dev_lad == 4'h0)
    else $error("wait or ready sync wrong");
  a_read_tail: assert property ($rose(dev_lad_oe) && dev_lad == 4'h5 |->
    ##3 dev_lad_oe [*2] ##1 dev_lad_oe && dev_lad == 4'hf ##1 !dev_lad_oe)
    else $error("read data or turnaround wrong");
  a_write_tail: assert property ($rose(dev_lad_oe) && dev_lad == 4'h0 |=>
    dev_lad_oe && dev_lad == 4'hf ##1 !dev_lad_oe)
    else $error("write ack turnaround wrong");
  a_drive_window: assert property (dev_lad_oe |-> cnt >= 5'd12 && cnt <= 5'd17)
    else $error("device drives outside its window");
endmodule

// ==== sim/lmt_tb.sv ====
// Purpose: Self-checking bench joining host end and device end
// Assumes: Flash core modelled as a byte derived from the address
// Notes:   Pins pass three flops, so each pin change waits 4 clocks
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module lmt_tb
  import lmt_pkg::*;
;
  logic        clk_i;
  logic        reset_n_i;
  logic        cmd_valid, cmd_write, abort, busy, tsl_n, wp_n;
  logic        cmd_ready, done, error, mem_rd, prog, blocked;
  logic        seen_prog, seen_blk, seen_rd, seen_drv;
  logic [31:0] cmd_addr;
  logic [7:0]  cmd_wdata, rdata, prog_data, prog_byte, mem_data;
  logic [18:0] mem_addr;
  int          miscompares, compares;

  lmt_lpc_if bus ();
  assign mem_data = mem_addr[7:0] ^ 8'h5a;

  lmt_host u_lmt_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .bus(bus), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .abort_i(abort),
    .cmd_ready_o(cmd_ready), .done_o(done), .error_o(error), .rdata_o(rdata));
  lmt_device u_lmt_device (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .bus(bus), .id_strap_i(4'h6),
    .top_sector_lock_n_i(tsl_n), .write_protect_n_i(wp_n), .busy_i(busy), .mem_rd_data_i(mem_data),
    .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .prog_o(prog), .prog_data_o(prog_data), .wr_blocked_o(blocked));
  lmt_checker u_lmt_checker (.clk_i(clk_i), .reset_n_i(reset_n_i), .lframe_n(bus.lframe_n),
    .host_lad(bus.host_lad), .host_lad_oe(bus.host_lad_oe), .dev_lad(bus.dev_lad),
    .dev_lad_oe(bus.dev_lad_oe), .lad(bus.lad));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (prog === 1'b1) begin
      seen_prog <= 1'b1;
      prog_byte <= prog_data;
    end
    if (blocked === 1'b1) seen_blk <= 1'b1;
    if (mem_rd === 1'b1) seen_rd <= 1'b1;
    if (bus.dev_lad_oe === 1'b1) seen_drv <= 1'b1;
  end

  function automatic logic [31:0] adr(input logic arr, input logic [18:0] off);
    return {8'hff, arr, 4'h6, off};
  endfunction

  task automatic settle();
    repeat (4) @(negedge clk_i);
  endtask

  // One host command; ab names the edge at which abort is high
  task automatic cyc(input logic wr, input logic [31:0] a, input logic [7:0] d, input int ab);
    @(negedge clk_i);
    `CHK("cmd_ready", 1'b1, cmd_ready)
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    {seen_prog, seen_blk, seen_rd, seen_drv} = 4'h0;
    for (int n = 0; n < 40 && done !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
      if (done !== 1'b1) begin
        @(negedge clk_i);
        cmd_valid = 1'b0;
        abort = (n + 1 == ab);
      end
    end
    `CHK("done", 1'b1, done)
    // Callers change pins and busy off the sampling edge
    @(negedge clk_i);
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    reset_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    settle();
  endtask

  task automatic t_lock_default();
    cyc(1'b0, adr(1'b0, LMT_SEC_BASE[10] + 19'h2), 8'h00, 0);
    `CHK("lock10", 8'h01, rdata)
    cyc(1'b0, adr(1'b0, LMT_SEC_BASE[0] + 19'h2), 8'h00, 0);
    `CHK("lock0", 8'h01, rdata)
    $display("lock_default done");
  endtask

  task automatic t_read();
    cyc(1'b0, adr(1'b1, 19'h12345), 8'h00, 0);
    `CHK("rdata", 8'h45 ^ 8'h5a, rdata)
    `CHK("mem_addr", 19'h12345, mem_addr)
    `CHK("mem_rd", 1'b1, seen_rd)
    `CHK("error", 1'b0, error)
    cyc(1'b0, adr(1'b0, 19'h12345), 8'h00, 0);
    `CHK("reg_rdata", 8'hff, rdata)
    `CHK("reg_mem_rd", 1'b0, seen_rd)
    $display("read done");
  endtask

  // Sectors 3 and 10 opened in the register, then pin pairings 10, 11 and 01, never both low
  task automatic t_pins();
    logic [1:0] pins [0:4] = '{2'b10, 2'b11, 2'b01, 2'b10, 2'b01};
    logic [3:0] sec  [0:4] = '{4'h3, 4'h3, 4'ha, 4'ha, 4'h3};
    logic       ok;
    cyc(1'b1, adr(1'b0, LMT_SEC_BASE[3] + 19'h2), 8'h00, 0);
    cyc(1'b1, adr(1'b0, LMT_SEC_BASE[10] + 19'h2), 8'h00, 0);
    for (int i = 0; i < 5; i++) begin
      {tsl_n, wp_n} = pins[i];
      settle();
      ok = (sec[i] == 4'ha) ? pins[i][1] : pins[i][0];
      cyc(1'b1, adr(1'b1, LMT_SEC_BASE[sec[i]] + 19'h40), 8'h30 + 8'(i), 0);
      `CHK("prog", ok, seen_prog)
      `CHK("blocked", !ok, seen_blk)
      if (ok) `CHK("prog_byte", 8'h30 + 8'(i), prog_byte)
    end
    cyc(1'b1, adr(1'b1, LMT_SEC_BASE[5]), 8'h11, 0);
    `CHK("locked", 1'b1, seen_blk)
    tsl_n = 1'b0;
    settle();
    cyc(1'b1, adr(1'b0, LMT_SEC_BASE[10] + 19'h2), 8'h04, 0);
    cyc(1'b0, adr(1'b1, LMT_SEC_BASE[10] + 19'h8), 8'h00, 0);
    `CHK("read_lock", 8'hff, rdata)
    {tsl_n, wp_n} = 2'b11;
    settle();
    $display("pins done");
  endtask

  // Pins frozen while the flash core is busy
  task automatic t_busy();
    busy = 1'b1;
    wp_n = 1'b0;
    settle();
    cyc(1'b1, adr(1'b1, LMT_SEC_BASE[3] + 19'h9), 8'h5c, 0);
    `CHK("held_prog", 1'b1, seen_prog)
    busy = 1'b0;
    settle();
    cyc(1'b1, adr(1'b1, LMT_SEC_BASE[3] + 19'h9), 8'h5c, 0);
    `CHK("new_pin", 1'b1, seen_blk)
    wp_n = 1'b1;
    settle();
    $display("busy done");
  endtask

  // Frame low in write clock 12, a clean write, then frame low in clock 13
  task automatic t_abort();
    cyc(1'b1, adr(1'b1, LMT_SEC_BASE[3] + 19'h7), 8'h77, 11);
    `CHK("abort_prog", 1'b0, seen_prog | seen_blk)
    `CHK("abort_drv", 1'b0, seen_drv)
    `CHK("abort_err", 1'b1, error)
    cyc(1'b1, adr(1'b1, LMT_SEC_BASE[3] + 19'h7), 8'h78, 0);
    `CHK("after_abort", 8'h78, prog_byte)
    cyc(1'b1, adr(1'b1, LMT_SEC_BASE[3] + 19'h7), 8'h79, 12);
    `CHK("late_abort_prog", 1'b1, seen_prog)
    `CHK("late_abort_byte", 8'h79, prog_byte)
    $display("abort done");
  endtask

  task automatic t_foreign();
    cyc(1'b0, {8'hff, 1'b1, 4'h9, 19'h00100}, 8'h00, 0);
    `CHK("foreign_drv", 1'b0, seen_drv)
    `CHK("foreign_err", 1'b1, error)
    $display("foreign done");
  endtask

  task automatic t_reset();
    cyc(1'b1, adr(1'b0, LMT_SEC_BASE[0] + 19'h2), 8'h00, 0);
    do_reset();
    t_lock_default();
    $display("reset done");
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    {cmd_valid, cmd_write, abort, busy} = 4'h0;
    {tsl_n, wp_n} = 2'b11;
    {cmd_addr, cmd_wdata} = 40'h0;
    {seen_prog, seen_blk, seen_rd, seen_drv} = 4'h0;
    reset_n_i = 1'b0;
    do_reset();
    t_lock_default();
    t_read();
    t_pins();
    t_busy();
    t_abort();
    t_foreign();
    t_reset();
    finish_test();
  end

  // Tests need about 520 clocks
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
endmodule
